// ===== logic/bridge_cfg_map.svh
// Offsets, reset values and field positions of the bridge config block.
// Assumes byte-wide config accesses at the printed offsets.
// Operation
// (R1) Colour forward and mono present both clear: all display references go to PCI.
// (R2) Software never programs colour forward clear with mono present set.
// (R3) Colour forward only: colour to AGP, only port 3BFh aliases to PCI.
// (R4) Both bits set: colour to AGP, all monochrome references to PCI.
// (R5) Mono memory B0000h-B7FFFh and listed ports with aliases; partial overlap counts.
// (R6) Buffer control at 53h, resets to 83h, bits 7 and 4:0 reserved.
// (R7) Bit 6 set posts processor-to-PCI IDE writes; clear gives unposted writes.
// (R8) Bit 5 set keeps write-combining posting during I/O bridge PCI ownership.
// (R9) Software sets bit 5 only with a write-combining region on PCI.
// (R10) Row type register 16 bits at 55h-56h, resets 0000h, read/write.
// (R11) Two-bit field per row; bits 1:0 row 0 up to bits 9:8 row 4.
// (R12) Field codes: 00 EDO, 01 reserved, 10 SDRAM, 11 empty row.
// (R13) Memory controller picks row timing from its type field before each cycle.
// (R14) Firmware programs each row type to match installed memory.
`ifndef BRIDGE_CFG_MAP_SVH
`define BRIDGE_CFG_MAP_SVH
`define AGPCTL_OFF 8'h51
`define BUFCTL_OFF 8'h53
`define ROWLO_OFF 8'h55
`define ROWHI_OFF 8'h56
`define BUFCTL_RST 8'h83
`define ROWTYPE_RST 16'h0000
`define AGPCTL_RST 8'h00
`define BUFCTL_RSVD 8'h9F
`define MONO_BIT 5
`define IDE_BIT 6
`define WCP_BIT 5
`define ROWCODE_EDO 2'h0
`define ROWCODE_SDR 2'h2
`define ROWCODE_NONE 2'h3
`define MONO_MEM_LO 20'hB0000
`define MONO_MEM_HI 20'hB7FFF
`define COL_MEM_LO 20'hA0000
`define COL_MEM_HI 20'hBFFFF
`endif

// ===== logic/bridge_cfg_pkg.sv
// Types shared by the bridge configuration block.
// Assumes the map header supplies all numeric constants.
package bridge_cfg_pkg;
   typedef enum logic [1:0] {ROW_EDO, ROW_SDRAM, ROW_EMPTY, ROW_RSVD} rowkind_e;
endpackage : bridge_cfg_pkg

// ===== logic/bridge_cfg.sv
// Routing decode, buffer control and row type configuration registers.
// Assumes a single-cycle byte config port on ref_clk; display references
// and row selects come from same-clock logic.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "bridge_cfg_map.svh"
module bridge_cfg
   import bridge_cfg_pkg::*;
#(
   parameter int ROWS = 5
)
(
   // Clock and reset
   input wire logic refClk,
   input wire logic rst_n,
   // Config port
   input wire logic [7:0] cfgAddr,
   input wire logic [7:0] cfgWdata,
   input wire logic cfgWr,
   input wire logic cfgRd,
   output logic [7:0] cfgRdata,
   // Colour forward from the bridge control of the AGP side
   input wire logic colourFwdEn,
   // Display reference lookup
   input wire logic refValid,
   input wire logic refIsIo,
   input wire logic [19:0] refMemAddr,
   input wire logic [15:0] refIoAddr,
   input wire logic [3:0] refIoBe,
   output logic refToAgp,
   output logic refToPci,
   // Buffer control outputs
   output logic ide_write_post_en,
   output logic wc_post_during_iob_en,
   // Memory controller row timing
   input wire logic [2:0] cycleRow,
   output logic [1:0] rowKind
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0] agpCtl;
      logic [7:0] bufCtl;
      logic [15:0] rowType;
      logic [7:0] rdData;
      logic toAgp;
      logic toPci;
      logic [1:0] kind;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // ==========================================================
   // Monochrome port match, low ten bits only (ISA aliases)
   function automatic logic monoPort(input logic [9:0] a);
      monoPort = (a == 10'h3B4) || (a == 10'h3B5) || (a == 10'h3B8) ||
         (a == 10'h3B9) || (a == 10'h3BA) || (a == 10'h3BF);
   endfunction : monoPort

   logic [3:0] laneMono;
   logic [3:0] laneMonoOnly;
   logic [3:0] laneColour;
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : gLane
         logic [9:0] lanePort;
         assign lanePort = {refIoAddr[9:2], 2'(g)};
         assign laneMono[g] = refIoBe[g] && monoPort(lanePort);
         assign laneMonoOnly[g] = refIoBe[g] && (lanePort == 10'h3BF);
         assign laneColour[g] = refIoBe[g] && (lanePort >= 10'h3B0)
            && (lanePort <= 10'h3DF);
      end
   endgenerate

   logic memMono;
   logic memColour;
   logic isMono;
   logic isMonoOnly;
   logic isColour;
   assign memMono = (refMemAddr >= `MONO_MEM_LO) &&
      (refMemAddr <= `MONO_MEM_HI);
   assign memColour = (refMemAddr >= `COL_MEM_LO) &&
      (refMemAddr <= `COL_MEM_HI);
   // Any touched lane wins, even alongside unrelated ports
   assign isMono = refIsIo ? (|laneMono) : memMono; // R5
   assign isMonoOnly = refIsIo && (|laneMonoOnly);
   assign isColour = refIsIo ? (|laneColour) : memColour;

   // ==========================================================
   // Next state
   logic monoPresent;
   logic [2:0] rowIdx;
   logic [1:0] code;
   always_comb
   begin
      st_nxt = st_r;
      monoPresent = st_r.agpCtl[`MONO_BIT];
      rowIdx = (cycleRow < 3'(ROWS)) ? cycleRow : 3'h0;
      code = st_r.rowType[{rowIdx, 1'b0} +: 2]; // R11
      st_nxt.rdData = 8'h00;
      if (cfgWr)
      begin
         if (cfgAddr == `AGPCTL_OFF)
            st_nxt.agpCtl = cfgWdata & 8'h20;
         else if (cfgAddr == `BUFCTL_OFF)
            st_nxt.bufCtl = (cfgWdata & ~`BUFCTL_RSVD) |
               (st_r.bufCtl & `BUFCTL_RSVD); // R6
         else if (cfgAddr == `ROWLO_OFF)
            st_nxt.rowType[7:0] = cfgWdata; // R10
         else if (cfgAddr == `ROWHI_OFF)
            st_nxt.rowType[15:8] = cfgWdata; // R10
      end
      if (cfgRd)
      begin
         if (cfgAddr == `AGPCTL_OFF)
            st_nxt.rdData = st_r.agpCtl;
         else if (cfgAddr == `BUFCTL_OFF)
            st_nxt.rdData = st_r.bufCtl; // R6
         else if (cfgAddr == `ROWLO_OFF)
            st_nxt.rdData = st_r.rowType[7:0]; // R10
         else if (cfgAddr == `ROWHI_OFF)
            st_nxt.rdData = st_r.rowType[15:8]; // R10
         else
            st_nxt.rdData = 8'h00;
      end
      // Routing: reserved combination treated like both clear
      st_nxt.toAgp = 1'b0;
      st_nxt.toPci = 1'b0;
      if (refValid && (isMono || isColour))
      begin
         if (!colourFwdEn)
            st_nxt.toPci = 1'b1; // R1
         else if (monoPresent)
         begin
            st_nxt.toPci = isMono; // R4
            st_nxt.toAgp = !isMono; // R4
         end
         else
         begin
            st_nxt.toPci = isMonoOnly; // R3
            st_nxt.toAgp = !isMonoOnly; // R3
         end
      end
      // Timing selection registered ahead of the cycle start
      case (code) // R12
         `ROWCODE_EDO: st_nxt.kind = ROW_EDO; // R13
         `ROWCODE_SDR: st_nxt.kind = ROW_SDRAM; // R13
         `ROWCODE_NONE: st_nxt.kind = ROW_EMPTY; // R13
         default: st_nxt.kind = ROW_RSVD;
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge refClk)
   begin
      if (!rst_n)
      begin
         st_r.agpCtl <= `AGPCTL_RST;
         st_r.bufCtl <= `BUFCTL_RST; // R6
         st_r.rowType <= `ROWTYPE_RST; // R10
         st_r.rdData <= 8'h00;
         st_r.toAgp <= 1'b0;
         st_r.toPci <= 1'b0;
         st_r.kind <= ROW_EDO;
      end
      else
         st_r <= st_nxt;
   end

   assign cfgRdata = st_r.rdData;
   assign refToAgp = st_r.toAgp;
   assign refToPci = st_r.toPci;
   assign ide_write_post_en = st_r.bufCtl[`IDE_BIT]; // R7
   assign wc_post_during_iob_en = st_r.bufCtl[`WCP_BIT]; // R8
   assign rowKind = st_r.kind;

endmodule : bridge_cfg

// ===== verif/bridge_cfg_checker.sv
// Port assertions for bridge_cfg.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module bridge_cfg_checker (
   // Clock, reset, config port
   input wire logic refClk,
   input wire logic rst_n,
   input wire logic [7:0] cfgAddr,
   input wire logic [7:0] cfgWdata,
   input wire logic cfgWr,
   input wire logic cfgRd,
   input wire logic [7:0] cfgRdata,
   // Routing and posting
   input wire logic refValid,
   input wire logic refToAgp,
   input wire logic refToPci,
   input wire logic ide_write_post_en,
   input wire logic wc_post_during_iob_en
);
   default clocking cb @(posedge refClk); endclocking
   default disable iff (!rst_n);
   sequence bufWr;
      cfgWr && cfgAddr == 8'h53;
   endsequence
   sequence bufRd;
      cfgRd && cfgAddr == 8'h53;
   endsequence
   ide_post_a: assert property (bufWr |=> ide_write_post_en ==
      $past(cfgWdata[6])) else $error("ide post");
   wc_post_a: assert property (bufWr |=> wc_post_during_iob_en ==
      $past(cfgWdata[5])) else $error("wc post");
   post_rst_a: assert property ($rose(rst_n) |->
      !ide_write_post_en && !wc_post_during_iob_en) else $error("rst");
   buf_rsvd_a: assert property (bufRd |=> cfgRdata[7] &&
      cfgRdata[4:0] == 5'h03) else $error("reserved");
   buf_bits_a: assert property (bufRd |=> cfgRdata[6:5] ==
      {ide_write_post_en, wc_post_during_iob_en}) else $error("bits");
   rd_idle_a: assert property (!cfgRd |=> cfgRdata == 8'h00)
      else $error("rdata");
   route_one_a: assert property (refValid |=> !(refToAgp && refToPci))
      else $error("route");
   route_idle_a: assert property (!refValid |=> !refToAgp && !refToPci)
      else $error("idle");
endmodule : bridge_cfg_checker
bind bridge_cfg bridge_cfg_checker chk (.refClk(refClk), .rst_n(rst_n),
   .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgWr(cfgWr), .cfgRd(cfgRd),
   .cfgRdata(cfgRdata), .refValid(refValid), .refToAgp(refToAgp),
   .refToPci(refToPci), .ide_write_post_en(ide_write_post_en),
   .wc_post_during_iob_en(wc_post_during_iob_en));

// ===== verif/test_bridge_cfg.sv
// Bench for bridge_cfg: registers, display routing, row type lookup.
// Assumes single-cycle config port and one-cycle registered outputs.
`timescale 1ns/1ps
module test_bridge_cfg
   import bridge_cfg_pkg::*;
;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, fwd = 0, rv = 0, io = 0;
   logic [7:0] ad = 0, wd = 0, rdat;
   logic [19:0] ma = 0;
   logic [3:0] be = 0;
   logic [2:0] row = 0;
   logic agp, pci, ip, wp;
   logic [1:0] kind;
   int err_total = 0, num_checks = 0, cyc = 0;
   rowkind_e kinds[5] = '{ROW_EDO, ROW_RSVD, ROW_SDRAM, ROW_EMPTY, ROW_SDRAM};
   bridge_cfg DUT (.refClk(clk), .rst_n(rst_n), .cfgAddr(ad), .cfgWdata(wd),
      .cfgWr(wr), .cfgRd(rd), .cfgRdata(rdat), .colourFwdEn(fwd),
      .refValid(rv), .refIsIo(io), .refMemAddr(ma), .refIoAddr(ma[15:0]),
      .refIoBe(be), .refToAgp(agp), .refToPci(pci), .ide_write_post_en(ip),
      .wc_post_during_iob_en(wp), .cycleRow(row), .rowKind(kind));
   always #10 clk = ~clk;
   // Whole run is well under 400 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_total++;
         results();
      end
   end
   task results;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   task chk(input logic [7:0] g, e);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task wrt(input logic [7:0] a, d);
      @(posedge clk);
      {wr, ad, wd} <= {1'b1, a, d};
      @(posedge clk);
      wr <= 1'b0;
   endtask : wrt
   task rdc(input logic [7:0] a, e);
      @(posedge clk);
      {rd, ad} <= {1'b1, a};
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdat, e);
   endtask : rdc
   task rt(input logic i, input logic [19:0] m, input logic [3:0] b,
      input logic [1:0] e);
      @(posedge clk);
      {rv, io, ma, be} <= {1'b1, i, m, b};
      @(posedge clk);
      rv <= 1'b0;
      #1 chk({6'h00, agp, pci}, {6'h00, e});
   endtask : rt
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rdc(8'h53, 8'h83);
      rdc(8'h56, 8'h00);
      chk({6'h00, ip, wp}, 8'h00);
      wrt(8'h53, 8'hFF);
      rdc(8'h53, 8'hE3);
      chk({6'h00, ip, wp}, 8'h03);
      wrt(8'h53, 8'h40);
      rdc(8'h53, 8'hC3);
      chk({6'h00, ip, wp}, 8'h02);
      rdc(8'h60, 8'h00);
      $display("buffer control done");
      wrt(8'h55, 8'hE4);
      wrt(8'h56, 8'hFE);
      rdc(8'h55, 8'hE4);
      rdc(8'h56, 8'hFE);
      for (int r = 0; r < 5; r++)
      begin
         @(posedge clk);
         row <= 3'(r);
         @(posedge clk);
         #1 chk({6'h00, kind}, {6'h00, kinds[r]});
      end
      $display("row type done");
      rt(0, 20'hA0000, 4'h0, 2'b01);
      rt(1, 20'h003BC, 4'h8, 2'b01);
      @(posedge clk);
      fwd <= 1'b1;
      rt(0, 20'hB0000, 4'h0, 2'b10);
      rt(1, 20'h007BC, 4'h8, 2'b01);
      rt(1, 20'h003B4, 4'h1, 2'b10);
      wrt(8'h51, 8'h20);
      rt(0, 20'hB7FFF, 4'h0, 2'b01);
      rt(1, 20'h003B4, 4'hF, 2'b01);
      rt(0, 20'hA0000, 4'h0, 2'b10);
      $display("routing done");
      results();
   end
endmodule : test_bridge_cfg
